// file: sqp_sram_ports.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module sqp_sram_ports (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_k,
    input wire logic clk_k_n,
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    input wire logic [sqp_pkg::ADDR_W-1:0] address_in,
    input wire logic [sqp_pkg::DATA_W-1:0] write_data_in,
    input wire logic [sqp_pkg::LANES-1:0] byte_lane_mask_n,
    input wire logic loop_disable_n,
    input wire logic termination_enable,
    input wire logic [sqp_pkg::IMP_W-1:0] drive_target_in,
    input wire logic [sqp_pkg::IMP_W-1:0] term_target_in,
    output logic [sqp_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe_n,
    output logic output_valid_flag,
    output logic echo_timebase,
    output logic echo_timebase_n,
    output logic termination_active,
    output logic loop_active,
    output logic [sqp_pkg::IMP_W-1:0] drive_imp_code,
    output logic [sqp_pkg::IMP_W-1:0] term_imp_code
);
    localparam int P_K = 0;
    localparam int P_KN = 1;
    localparam int P_R = 2;
    localparam int P_W = 3;
    localparam int P_A = 4;
    localparam int P_D = P_A + sqp_pkg::ADDR_W;
    localparam int P_M = P_D + sqp_pkg::DATA_W;
    localparam int P_DOFF = P_M + sqp_pkg::LANES;
    localparam int P_ODT = P_DOFF + 1;
    localparam int P_TD = P_ODT + 1;
    localparam int P_TT = P_TD + sqp_pkg::IMP_W;

    logic [sqp_pkg::PIN_W-1:0] pin_s1_ff;
    logic [sqp_pkg::PIN_W-1:0] pin_s2_ff;
    logic k_prev_ff;
    logic kn_prev_ff;
    logic k_rise;
    logic kn_rise;
    logic rd_cmd;
    logic wr_cmd;
    logic [sqp_pkg::ADDR_W-1:0] pin_addr;
    logic [sqp_pkg::DATA_W-1:0] pin_data;
    logic [sqp_pkg::LANES-1:0] pin_mask_n;

    // Pins first pass two flops; the second stage alone feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= {term_target_in, drive_target_in, termination_enable,
                loop_disable_n, byte_lane_mask_n, write_data_in, address_in,
                write_sel_n, read_sel_n, clk_k_n, clk_k};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k_prev_ff <= 1'b0;
            kn_prev_ff <= 1'b0;
        end else begin
            k_prev_ff <= pin_s2_ff[P_K];
            kn_prev_ff <= pin_s2_ff[P_KN];
        end
    end

    // All pins share one delay, so edge and data stay aligned
    assign k_rise = pin_s2_ff[P_K] & ~k_prev_ff;
    assign kn_rise = pin_s2_ff[P_KN] & ~kn_prev_ff;
    assign pin_addr = pin_s2_ff[P_D-1:P_A];
    assign pin_data = pin_s2_ff[P_M-1:P_D];
    assign pin_mask_n = pin_s2_ff[P_DOFF-1:P_M];
    assign rd_cmd = k_rise & ~pin_s2_ff[P_R];
    assign wr_cmd = k_rise & ~pin_s2_ff[P_W];

    // Write port
    logic wr_pend_ff;
    logic [sqp_pkg::DATA_W-1:0] wr_beat0_ff;
    logic [sqp_pkg::LANES-1:0] wr_mask0_n_ff;
    logic mem_wr_en;
    logic [2*sqp_pkg::LANES-1:0] mem_lane_en;
    logic [sqp_pkg::WORD_W-1:0] mem_wr_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_pend_ff <= 1'b0;
            wr_beat0_ff <= '0;
            wr_mask0_n_ff <= '1;
        end else if (k_rise) begin
            wr_pend_ff <= wr_cmd;
            if (wr_cmd) begin
                wr_beat0_ff <= pin_data;
                wr_mask0_n_ff <= pin_mask_n;
            end
        end else if (kn_rise) begin
            wr_pend_ff <= 1'b0;
        end
    end

    assign mem_wr_en = kn_rise & wr_pend_ff;
    assign mem_wr_data = {pin_data, wr_beat0_ff};
    assign mem_lane_en = {sqp_pkg::lane_we(pin_mask_n),
        sqp_pkg::lane_we(wr_mask0_n_ff)};

    // Read port pipeline, counted in primary clock rises
    logic rd_v0_ff;
    logic rd_v1_ff;
    logic [sqp_pkg::WORD_W-1:0] rd_hold_ff;
    logic [sqp_pkg::DATA_W-1:0] rd_upper_ff;
    logic [sqp_pkg::WORD_W-1:0] mem_rd_data;
    sqp_pkg::sqp_out_state_t out_state_ff;
    logic [sqp_pkg::DATA_W-1:0] q_ff;
    logic q_oe_n_ff;
    logic q_valid_ff;
    logic echo_ff;
    logic echo_n_ff;

    sqp_word_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(mem_wr_en),
        .wr_addr(pin_addr),
        .wr_lane_en(mem_lane_en),
        .wr_data(mem_wr_data),
        .rd_en(rd_cmd),
        .rd_addr(pin_addr),
        .rd_data(mem_rd_data)
    );

    // Array data is ready one pclk after the read, well before the next rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_v0_ff <= 1'b0;
            rd_v1_ff <= 1'b0;
            rd_hold_ff <= '0;
        end else if (k_rise) begin
            rd_v0_ff <= rd_cmd;
            rd_v1_ff <= rd_v0_ff;
            if (rd_v0_ff) begin
                rd_hold_ff <= mem_rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_state_ff <= sqp_pkg::OUT_IDLE;
            q_ff <= '0;
            q_oe_n_ff <= 1'b1;
            q_valid_ff <= 1'b0;
            rd_upper_ff <= '0;
        end else begin
            case (out_state_ff)
                sqp_pkg::OUT_IDLE, sqp_pkg::OUT_BEAT1: begin
                    if (k_rise && rd_v1_ff) begin
                        out_state_ff <= sqp_pkg::OUT_BEAT0;
                        q_ff <= rd_hold_ff[sqp_pkg::DATA_W-1:0];
                        rd_upper_ff <= rd_hold_ff[sqp_pkg::WORD_W-1:sqp_pkg::DATA_W];
                        q_oe_n_ff <= 1'b0;
                        q_valid_ff <= 1'b1;
                    end else if (k_rise) begin
                        out_state_ff <= sqp_pkg::OUT_IDLE;
                        q_oe_n_ff <= 1'b1;
                        q_valid_ff <= 1'b0;
                    end
                end
                sqp_pkg::OUT_BEAT0: begin
                    if (kn_rise) begin
                        out_state_ff <= sqp_pkg::OUT_BEAT1;
                        q_ff <= rd_upper_ff;
                    end else if (k_rise) begin
                        // Complement rise missed: close the slot cleanly
                        out_state_ff <= sqp_pkg::OUT_IDLE;
                        q_oe_n_ff <= 1'b1;
                        q_valid_ff <= 1'b0;
                    end
                end
                default: begin
                    out_state_ff <= sqp_pkg::OUT_IDLE;
                    q_oe_n_ff <= 1'b1;
                    q_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_ff <= 1'b0;
            echo_n_ff <= 1'b1;
        end else if (k_rise) begin
            echo_ff <= 1'b1;
            echo_n_ff <= 1'b0;
        end else if (kn_rise) begin
            echo_ff <= 1'b0;
            echo_n_ff <= 1'b1;
        end
    end

    // Termination and loop straps
    logic term_active_ff;
    logic loop_active_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_active_ff <= 1'b0;
            loop_active_ff <= 1'b0;
        end else begin
            term_active_ff <= pin_s2_ff[P_ODT];
            loop_active_ff <= pin_s2_ff[P_DOFF];
        end
    end

    // APB registers
    logic [31:0] ctrl_ff;
    logic [15:0] period_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic apb_done;
    logic addr_hit;
    logic [31:0] rd_mux;
    logic [sqp_pkg::IMP_W-1:0] drv_code;
    logic [sqp_pkg::IMP_W-1:0] term_code;

    assign apb_done = psel & penable & pready_ff;
    assign addr_hit = (paddr == sqp_pkg::OFS_CTRL) || (paddr == sqp_pkg::OFS_PERIOD) ||
        (paddr == sqp_pkg::OFS_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            sqp_pkg::OFS_CTRL: rd_mux = ctrl_ff;
            sqp_pkg::OFS_PERIOD: rd_mux = {16'h0000, period_ff};
            sqp_pkg::OFS_STATUS: begin
                rd_mux[sqp_pkg::STAT_DRV_LSB +: sqp_pkg::IMP_W] = drv_code;
                rd_mux[sqp_pkg::STAT_TERM_LSB +: sqp_pkg::IMP_W] = term_code;
                rd_mux[sqp_pkg::STAT_TERM_EN_BIT] = term_active_ff;
                rd_mux[sqp_pkg::STAT_LOOP_ON_BIT] = loop_active_ff;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~addr_hit;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= sqp_pkg::CTRL_RESET;
            period_ff <= sqp_pkg::PERIOD_RESET;
        end else if (apb_done && pwrite) begin
            if (paddr == sqp_pkg::OFS_CTRL) begin
                ctrl_ff <= {31'h0000_0000, pwdata[sqp_pkg::CTRL_CAL_EN_BIT]};
            end
            if (paddr == sqp_pkg::OFS_PERIOD) begin
                period_ff <= pwdata[15:0];
            end
        end
    end

    // Calibration timer shared by driver and termination
    logic [15:0] cal_cnt_ff;
    logic cal_trig;

    assign cal_trig = ctrl_ff[sqp_pkg::CTRL_CAL_EN_BIT] &&
        ((cal_cnt_ff >= period_ff - 16'h0001) || (period_ff == 16'h0000));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_ff <= '0;
        end else if (cal_trig) begin
            cal_cnt_ff <= '0;
        end else begin
            cal_cnt_ff <= cal_cnt_ff + 16'h0001;
        end
    end

    sqp_imp_step u_drv_cal (
        .clk(pclk),
        .rst_n(presetn),
        .step_req(cal_trig),
        .target(pin_s2_ff[P_TT-1:P_TD]),
        .code(drv_code)
    );

    // Same trigger steps the termination code
    sqp_imp_step u_term_cal (
        .clk(pclk),
        .rst_n(presetn),
        .step_req(cal_trig),
        .target(pin_s2_ff[P_TT+sqp_pkg::IMP_W-1:P_TT]),
        .code(term_code)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign read_data_out = q_ff;
    assign read_data_oe_n = q_oe_n_ff;
    assign output_valid_flag = q_valid_ff;
    assign echo_timebase = echo_ff;
    assign echo_timebase_n = echo_n_ff;
    assign termination_active = term_active_ff;
    assign loop_active = loop_active_ff;
    assign drive_imp_code = drv_code;
    assign term_imp_code = term_code;
endmodule

// file: sqp_pkg.sv
package sqp_pkg;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int WORD_W = 2 * DATA_W;
    localparam int ADDR_W = 8;
    localparam int IMP_W = 6;
    localparam int PIN_W = 4 + ADDR_W + DATA_W + LANES + 2 + 2 * IMP_W;

    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PERIOD = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    localparam int CTRL_CAL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [15:0] PERIOD_RESET = 16'h0400;
    localparam int STAT_DRV_LSB = 0;
    localparam int STAT_TERM_LSB = 8;
    localparam int STAT_TERM_EN_BIT = 16;
    localparam int STAT_LOOP_ON_BIT = 17;
    localparam logic [IMP_W-1:0] IMP_RESET = 6'h20;

    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_BEAT0,
        OUT_BEAT1
    } sqp_out_state_t;

    // Active-low lane masks to per-lane write enables
    function automatic logic [LANES-1:0] lane_we(input logic [LANES-1:0] mask_n);
        return ~mask_n;
    endfunction
endpackage

// file: sqp_word_mem.sv
`timescale 1ns/1ps
module sqp_word_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [sqp_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [2*sqp_pkg::LANES-1:0] wr_lane_en,
    input wire logic [sqp_pkg::WORD_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [sqp_pkg::ADDR_W-1:0] rd_addr,
    output logic [sqp_pkg::WORD_W-1:0] rd_data
);
    logic [sqp_pkg::WORD_W-1:0] mem [0:(1<<sqp_pkg::ADDR_W)-1];
    logic [sqp_pkg::WORD_W-1:0] rd_data_ff;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            for (int i = 0; i < 2 * sqp_pkg::LANES; i++) begin
                if (wr_lane_en[i]) begin
                    mem[wr_addr][i*sqp_pkg::LANE_W +: sqp_pkg::LANE_W] <=
                        wr_data[i*sqp_pkg::LANE_W +: sqp_pkg::LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else if (rd_en) begin
            rd_data_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;
endmodule

// file: sqp_imp_step.sv
`timescale 1ns/1ps
module sqp_imp_step (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step_req,
    input wire logic [sqp_pkg::IMP_W-1:0] target,
    output logic [sqp_pkg::IMP_W-1:0] code
);
    logic [sqp_pkg::IMP_W-1:0] code_ff;

    // One step per evaluation keeps the driver from jumping mid-burst
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= sqp_pkg::IMP_RESET;
        end else if (step_req) begin
            if (target > code_ff) begin
                code_ff <= code_ff + 1'b1;
            end else if (target < code_ff) begin
                code_ff <= code_ff - 1'b1;
            end
        end
    end

    assign code = code_ff;
endmodule

// file: sqp_sram_ports_asserts.sv
`timescale 1ns/1ps
module sqp_sram_ports_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [sqp_pkg::DATA_W-1:0] read_data_out,
    input wire logic read_data_oe_n,
    input wire logic output_valid_flag,
    input wire logic echo_timebase,
    input wire logic echo_timebase_n,
    input wire logic termination_enable,
    input wire logic termination_active,
    input wire logic loop_disable_n,
    input wire logic loop_active,
    input wire logic [sqp_pkg::IMP_W-1:0] drive_target_in,
    input wire logic [sqp_pkg::IMP_W-1:0] drive_imp_code,
    input wire logic [sqp_pkg::IMP_W-1:0] term_imp_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not on second access cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready && psel |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("pslverr wrong for address");
    a_valid_oe: assert property (output_valid_flag == !read_data_oe_n)
        else $error("valid flag and output enable disagree");
    a_echo_pair: assert property (echo_timebase == !echo_timebase_n)
        else $error("echo outputs not complementary");
    a_beat_start: assert property ($rose(output_valid_flag) |-> $rose(echo_timebase))
        else $error("read beat not aligned to echo rise");
    a_beat_hold: assert property (output_valid_flag && $past(output_valid_flag)
        && $stable(echo_timebase) |-> $stable(read_data_out))
        else $error("read beat changed mid beat");
    a_drive_step: assert property ($changed(drive_imp_code) |->
        6'(drive_imp_code - $past(drive_imp_code)) inside {6'h01, 6'h3f})
        else $error("drive code moved more than one step");
    a_term_step: assert property ($changed(term_imp_code) |->
        6'(term_imp_code - $past(term_imp_code)) inside {6'h01, 6'h3f})
        else $error("term code moved more than one step");
    a_drive_toward: assert property (drive_imp_code > $past(drive_imp_code) |->
        drive_imp_code <= drive_target_in)
        else $error("drive code moved away from target");
    a_term_follow: assert property ($rose(termination_enable) |->
        ##[1:4] termination_active)
        else $error("termination not enabled");
    a_loop_off: assert property ($fell(loop_disable_n) |-> ##[1:4] !loop_active)
        else $error("loop not switched off");
endmodule
bind sqp_sram_ports sqp_sram_ports_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .read_data_out(read_data_out), .read_data_oe_n(read_data_oe_n),
    .output_valid_flag(output_valid_flag), .echo_timebase(echo_timebase),
    .echo_timebase_n(echo_timebase_n), .termination_enable(termination_enable),
    .termination_active(termination_active), .loop_disable_n(loop_disable_n),
    .loop_active(loop_active), .drive_target_in(drive_target_in),
    .drive_imp_code(drive_imp_code), .term_imp_code(term_imp_code));

// file: sqp_ctrl_model.sv
`timescale 1ns/1ps
module sqp_ctrl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic r_n,
    input wire logic w_n,
    input wire logic [7:0] ra,
    input wire logic [7:0] wa,
    input wire logic [71:0] wd,
    input wire logic [7:0] wm,
    output logic tick,
    output logic clk_k,
    output logic clk_k_n,
    output logic read_sel_n,
    output logic write_sel_n,
    output logic [7:0] address_in,
    output logic [35:0] write_data_in,
    output logic [3:0] byte_lane_mask_n
);
    logic [2:0] ph_ff;
    logic [7:0] wa_ff;
    logic [35:0] d1_ff;
    logic [3:0] m1_ff;
    // Slot request is latched one pclk ahead of the clk_k rise
    assign tick = (ph_ff == 3'h7);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_ff <= 3'h0;
            clk_k <= 1'b0;
            clk_k_n <= 1'b1;
            read_sel_n <= 1'b1;
            write_sel_n <= 1'b1;
            address_in <= 8'h00;
            write_data_in <= 36'h0;
            byte_lane_mask_n <= 4'hf;
        end else begin
            ph_ff <= ph_ff + 3'h1;
            case (ph_ff)
                3'h7: begin
                    read_sel_n <= r_n;
                    write_sel_n <= w_n;
                    address_in <= ra;
                    // Unused data lines toggle, never float
                    write_data_in <= w_n ? ~write_data_in : wd[35:0];
                    byte_lane_mask_n <= wm[3:0];
                    wa_ff <= wa;
                    d1_ff <= wd[71:36];
                    m1_ff <= wm[7:4];
                end
                3'h0: begin
                    clk_k <= 1'b1;
                    clk_k_n <= 1'b0;
                end
                3'h3: begin
                    address_in <= wa_ff;
                    write_data_in <= write_sel_n ? ~write_data_in : d1_ff;
                    byte_lane_mask_n <= m1_ff;
                end
                3'h4: begin
                    clk_k <= 1'b0;
                    clk_k_n <= 1'b1;
                end
                default: ;
            endcase
        end
    end
endmodule

// file: sqp_sram_ports_tb_top.sv
`timescale 1ns/1ps
module sqp_sram_ports_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, r_n = 1'b1, w_n = 1'b1, tick, clk_k, clk_k_n, rsel_n, wsel_n;
    logic [7:0] ra = 8'h0, wa = 8'h0, wm = 8'h0, addr;
    logic [71:0] wd = 72'h0;
    logic [35:0] wdat, q, b0;
    logic [3:0] msk;
    logic loop_disable_n = 1'b1, termination_enable = 1'b0, oe_n, vld, ec, ec_n, t_act, l_act;
    logic [5:0] drive_target_in = 6'h20, term_target_in = 6'h20, dcode, tcode;
    logic e_q = 1'b0;
    logic [71:0] exp_mem [256];
    logic [71:0] expq[$], gotq[$];
    int err_count = 0, n_tests = 0, cyc = 0, kcnt = 0;
    int kq[$], kexp[$];
    always #2.5 pclk = ~pclk;
    sqp_ctrl_model u_far (.pclk(pclk), .presetn(presetn), .r_n(r_n), .w_n(w_n), .ra(ra),
        .wa(wa), .wd(wd), .wm(wm), .tick(tick), .clk_k(clk_k), .clk_k_n(clk_k_n),
        .read_sel_n(rsel_n), .write_sel_n(wsel_n), .address_in(addr),
        .write_data_in(wdat), .byte_lane_mask_n(msk));
    sqp_sram_ports u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_k(clk_k), .clk_k_n(clk_k_n), .read_sel_n(rsel_n),
        .write_sel_n(wsel_n), .address_in(addr), .write_data_in(wdat),
        .byte_lane_mask_n(msk), .loop_disable_n(loop_disable_n),
        .termination_enable(termination_enable), .drive_target_in(drive_target_in),
        .term_target_in(term_target_in), .read_data_out(q), .read_data_oe_n(oe_n),
        .output_valid_flag(vld), .echo_timebase(ec), .echo_timebase_n(ec_n),
        .termination_active(t_act), .loop_active(l_act), .drive_imp_code(dcode),
        .term_imp_code(tcode));
    // Beat 0 at echo rise, beat 1 at echo fall
    always @(posedge pclk) begin
        e_q <= ec;
        if (ec === 1'b1 && !e_q) kcnt++;
        if (vld === 1'b1 && ec === 1'b1 && !e_q) begin
            b0 <= q;
            kq.push_back(kcnt);
        end
        if (vld === 1'b1 && ec === 1'b0 && e_q) gotq.push_back({q, b0});
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic slot(input logic rn, input logic [7:0] ar, input logic wn,
                        input logic [7:0] aw, input logic [71:0] d, input logic [7:0] m);
        r_n <= rn;
        ra <= ar;
        w_n <= wn;
        wa <= aw;
        wd <= d;
        wm <= m;
        do @(posedge pclk); while (tick !== 1'b1);
        // Beat 0 comes with the second echo rise after the command's own
        if (!rn) kexp.push_back(kcnt + 3);
    endtask
    function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] d,
                                          input logic [7:0] m);
        logic [71:0] r;
        r = o;
        for (int i = 0; i < 8; i++) if (!m[i]) r[i*9 +: 9] = d[i*9 +: 9];
        return r;
    endfunction
    function automatic logic [71:0] pat(input int k);
        return 72'h123456789abcdef012 + 72'(k) * 72'h111111111111111111;
    endfunction
    task automatic t_reset();
        logic [31:0] rd;
        logic e;
        chk("oe_n", oe_n, 72'h1);
        chk("valid", vld, 72'h0);
        apb(1'b0, 12'h000, 32'h0, rd, e);
        chk("ctrl", rd, 72'h1);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        chk("period", rd, 72'h400);
        apb(1'b0, 12'h008, 32'h0, rd, e);
        chk("status", rd, 72'h22020);
        $display("done t_reset");
    endtask
    task automatic t_apb();
        logic [31:0] rd;
        logic e;
        apb(1'b1, 12'h004, 32'h4, rd, e);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        chk("period", rd, 72'h4);
        apb(1'b1, 12'h008, 32'hffffffff, rd, e);
        chk("ro err", e, 72'h0);
        apb(1'b0, 12'h008, 32'h0, rd, e);
        chk("status", rd, 72'h22020);
        apb(1'b0, 12'h00c, 32'h0, rd, e);
        chk("unmap rd", {e, rd}, 72'h100000000);
        apb(1'b1, 12'h010, 32'h5, rd, e);
        chk("unmap wr", e, 72'h1);
        $display("done t_apb");
    endtask
    task automatic t_rw();
        logic [7:0] mt [3] = '{8'ha5, 8'h0f, 8'h96};
        for (int i = 5; i < 8; i++) begin
            exp_mem[i] = pat(i);
            slot(1'b1, 8'h0, 1'b0, 8'(i), pat(i), 8'h00);
        end
        slot(1'b1, 8'h0, 1'b1, 8'h06, pat(9), 8'h00);
        for (int k = 0; k < 3; k++) begin
            expq.push_back(exp_mem[5]);
            exp_mem[7] = merge(exp_mem[7], pat(20 + k), mt[k]);
            slot(1'b0, 8'h05, 1'b0, 8'h07, pat(20 + k), mt[k]);
        end
        slot(1'b1, 8'h0, 1'b1, 8'h0, 72'h0, 8'h00);
        for (int i = 6; i < 8; i++) begin
            expq.push_back(exp_mem[i]);
            slot(1'b0, 8'(i), 1'b1, 8'h0, 72'h0, 8'h00);
        end
        repeat (4) slot(1'b1, 8'h0, 1'b1, 8'h0, 72'h0, 8'h00);
        chk("reads", gotq.size(), expq.size());
        while (gotq.size() > 0 && expq.size() > 0) begin
            chk("word", gotq.pop_front(), expq.pop_front());
        end
        while (kq.size() > 0 && kexp.size() > 0) begin
            chk("latency", kq.pop_front(), kexp.pop_front());
        end
        $display("done t_rw");
    endtask
    task automatic t_cal();
        logic [31:0] rd;
        logic e;
        apb(1'b1, 12'h000, 32'h0, rd, e);
        drive_target_in <= 6'h23;
        term_target_in <= 6'h1d;
        termination_enable <= 1'b1;
        repeat (100) @(posedge pclk);
        chk("held", {dcode, tcode}, 72'h820);
        chk("term on", t_act, 72'h1);
        apb(1'b1, 12'h000, 32'h1, rd, e);
        repeat (100) @(posedge pclk);
        chk("drive", dcode, 72'h23);
        chk("term", tcode, 72'h1d);
        loop_disable_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("loop", l_act, 72'h0);
        apb(1'b0, 12'h008, 32'h0, rd, e);
        chk("status", rd, 72'h11d23);
        $display("done t_cal");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_apb();
        t_rw();
        t_cal();
        give_verdict();
    end
endmodule
